// [hw/eeprom_consts.svh]
/*
 Constants of the serial non-volatile memory command block: op-codes,
 memory geometry and programming time. Assumes inclusion by bare name.
*/
`ifndef EEPROM_CONSTS_SVH
`define EEPROM_CONSTS_SVH

// op-code field: seven fixed bits, address bit 8 as lowest op-code bit
`define EE_OP_WRITE      7'h52
`define EE_OP_PAGE       7'h5a
`define EE_OP_READ       7'h54
// op-code field with all eight bits fixed
`define EE_OP_PROGRAM_ENABLE_CMD       8'ha3
`define EE_OP_PROGRAM_DISABLE_CMD       8'ha0

// geometry
`define EE_WORDS         512
`define EE_ADDR_W        9
`define EE_DATA_W        16
`define EE_PAGE_WORDS    8
`define EE_LAST_BIT      4'hf

// self-timed programming, longest time
`define EE_PROG_TIME_NS  5000000
`define EE_CORE_CLK_MHZ  20

// reset values
`define EE_WEL_RST       1'b0
`define EE_READY_RST     1'b1

`endif

// [hw/eeprom_pkg.sv]
/*
 Types of the serial non-volatile memory command block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package eeprom_pkg;

    typedef enum logic [2:0] {
        LS_IDLE,
        LS_HDR,
        LS_DATA,
        LS_READ,
        LS_DONE
    } link_state_t;

    typedef enum logic [2:0] {
        CK_NOP,
        CK_WRITE,
        CK_PAGE,
        CK_READ,
        CK_PROGRAM_ENABLE_CMD,
        CK_PROGRAM_DISABLE_CMD
    } cmd_kind_t;

endpackage

// [hw/serial_eeprom_cmd.sv]
/*
 Command and control logic of a 512 x 16 serial non-volatile memory:
 instruction receive on the serial clock, read data and status output,
 write-enable latch, write protection and abort by the reset pin, and the
 self-timed programming period on the core clock.
 Assumes serial_clock_in is a clock port; all other pins are asynchronous
 to core_clk. The memory array is only written while busy, and the link side
 refuses instructions while busy, so the link may read it directly.
*/
// Contract
// - select fall with clock high starts instruction
// - select fall with clock low gives status
// - status ends on select high or one-bit
// - output high impedance except status or read
// - input bits sampled on rising clock edge
// - read data changes on falling clock edge
// - eight op-code, eight address, sixteen data bits
// - early select rise abandons the instruction
// - writes refused until program enable executes
// - reads ignore the write-enable latch
// - no write while reset pin high
// - reset pin high aborts programming, back ready
// - read and enable commands ignore reset pin
// - instructions ignored while programming
// - ready pin low exactly while programming
// - busy and status need no serial clock
// - self-timed cycle within five milliseconds
// - storage is 512 words of sixteen bits
// - page write of up to eight words
// - single write starts after 32nd rising edge
// - read from 17th falling edge, auto increment
// - page wraps low bits, starts on select rise
`include "eeprom_consts.svh"

module serial_eeprom_cmd #(
    parameter int unsigned PROG_CYCLES = `EE_PROG_TIME_NS * `EE_CORE_CLK_MHZ / 1000
) (
    // core clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // serial link
    input  wire logic serial_clock_in,
    input  wire logic chip_select_n,
    input  wire logic serial_in,
    output logic      serial_out,
    output logic      serial_out_en,
    // programming control and status
    input  wire logic prog_abort,
    output logic      ready_out
);

    function automatic eeprom_pkg::cmd_kind_t op_kind(input logic [7:0] op);
        eeprom_pkg::cmd_kind_t k;
        k = eeprom_pkg::CK_NOP;
        if (op == `EE_OP_PROGRAM_ENABLE_CMD)
            k = eeprom_pkg::CK_PROGRAM_ENABLE_CMD;
        else if (op == `EE_OP_PROGRAM_DISABLE_CMD)
            k = eeprom_pkg::CK_PROGRAM_DISABLE_CMD;
        else if (op[7:1] == `EE_OP_WRITE)
            k = eeprom_pkg::CK_WRITE;
        else if (op[7:1] == `EE_OP_PAGE)
            k = eeprom_pkg::CK_PAGE;
        else if (op[7:1] == `EE_OP_READ)
            k = eeprom_pkg::CK_READ;
        return k;
    endfunction

    // memory, written on core_clk only at the end of programming
    logic [`EE_DATA_W-1:0]     mem_ff [`EE_WORDS];

    // link side
    logic                      link_clr;
    eeprom_pkg::link_state_t   state_ff;
    logic [3:0]                cnt_ff;
    logic [15:0]               shift_ff;
    logic [`EE_ADDR_W-1:0]     cmd_addr_ff;
    logic                      is_page_ff;
    logic                      status_req_ff;
    logic                      status_done_ff;
    logic                      status_mode;
    logic [15:0]               nxt_shift;
    logic                      hdr_done;
    logic                      word_done;
    eeprom_pkg::cmd_kind_t     hdr_kind;
    logic                      busy_l1_ff;
    logic                      busy_l2_ff;
    logic [`EE_DATA_W-1:0]     page_buf_ff [`EE_PAGE_WORDS];
    logic [`EE_PAGE_WORDS-1:0] page_mask_ff;
    logic [5:0]                page_base_ff;
    logic [2:0]                page_ptr_ff;
    logic                      page_armed_ff;
    logic                      go_tgl_ff;
    logic                      program_enable_cmd_tgl_ff;
    logic                      program_disable_cmd_tgl_ff;
    logic                      drive_ff;
    logic                      out_ff;
    logic [`EE_ADDR_W-1:0]     rd_ptr_ff;
    logic [3:0]                rd_idx_ff;
    logic [15:0]               rd_word_ff;

    // core side
    logic [2:0]                cs_sync_ff;
    logic [1:0]                abort_sync_ff;
    logic [1:0]                armed_sync_ff;
    logic [2:0]                go_sync_ff;
    logic [2:0]                program_enable_cmd_sync_ff;
    logic [2:0]                program_disable_cmd_sync_ff;
    logic                      wel_ff;
    logic                      ready_ff;
    logic [31:0]               timer_ff;
    logic                      prog_end;
    logic                      commit_req;
    logic [`EE_DATA_W-1:0]     cm_buf_ff [`EE_PAGE_WORDS];
    logic [`EE_PAGE_WORDS-1:0] cm_mask_ff;
    logic [5:0]                cm_base_ff;

    // deselect clears the receive state at once, no clock needed
    assign link_clr  = sys_rst | chip_select_n;
    assign nxt_shift = {shift_ff[14:0], serial_in};
    assign hdr_done  = (state_ff == eeprom_pkg::LS_HDR) && (cnt_ff == `EE_LAST_BIT);
    assign word_done = (state_ff == eeprom_pkg::LS_DATA) && (cnt_ff == `EE_LAST_BIT);
    assign hdr_kind  = op_kind(nxt_shift[15:8]);

    // level of the serial clock caught at the select fall picks the mode
    always_ff @(negedge chip_select_n or posedge sys_rst) begin
        if (sys_rst)
            status_req_ff <= 1'b0;
        else
            status_req_ff <= ~serial_clock_in;
    end

    // busy level into the link domain
    always_ff @(posedge serial_clock_in or posedge sys_rst) begin
        if (sys_rst) begin
            busy_l1_ff <= 1'b0;
            busy_l2_ff <= 1'b0;
        end else begin
            busy_l1_ff <= ~ready_ff;
            busy_l2_ff <= busy_l1_ff;
        end
    end

    // instruction receive
    always_ff @(posedge serial_clock_in or posedge link_clr) begin
        if (link_clr) begin
            state_ff       <= eeprom_pkg::LS_IDLE;
            cnt_ff         <= 4'h0;
            shift_ff       <= 16'h0000;
            cmd_addr_ff    <= '0;
            is_page_ff     <= 1'b0;
            status_done_ff <= 1'b0;
        end else begin
            case (state_ff)
                eeprom_pkg::LS_IDLE: begin
                    // in status mode a zero keeps waiting for the leading one
                    if (!status_req_ff || serial_in) begin
                        status_done_ff <= 1'b1;
                        shift_ff       <= nxt_shift;
                        cnt_ff         <= 4'h1;
                        state_ff       <= eeprom_pkg::LS_HDR;
                    end
                end
                eeprom_pkg::LS_HDR: begin
                    shift_ff <= nxt_shift;
                    cnt_ff   <= cnt_ff + 4'h1;
                    if (hdr_done) begin
                        cnt_ff      <= 4'h0;
                        cmd_addr_ff <= {nxt_shift[8], nxt_shift[7:0]};
                        is_page_ff  <= (hdr_kind == eeprom_pkg::CK_PAGE);
                        if (busy_l2_ff)
                            state_ff <= eeprom_pkg::LS_DONE;
                        else if (hdr_kind == eeprom_pkg::CK_READ)
                            state_ff <= eeprom_pkg::LS_READ;
                        else if (hdr_kind == eeprom_pkg::CK_WRITE || hdr_kind == eeprom_pkg::CK_PAGE)
                            state_ff <= eeprom_pkg::LS_DATA;
                        else
                            state_ff <= eeprom_pkg::LS_DONE;
                    end
                end
                eeprom_pkg::LS_DATA: begin
                    shift_ff <= nxt_shift;
                    cnt_ff   <= cnt_ff + 4'h1;
                    if (word_done && !is_page_ff)
                        state_ff <= eeprom_pkg::LS_DONE;
                end
                eeprom_pkg::LS_READ: state_ff <= eeprom_pkg::LS_READ;
                eeprom_pkg::LS_DONE: state_ff <= eeprom_pkg::LS_DONE;
                default:             state_ff <= eeprom_pkg::LS_DONE;
            endcase
        end
    end

    // write words, page pointer and events to the core side
    // survives deselect, so a page can be committed after select rises
    always_ff @(posedge serial_clock_in or posedge sys_rst) begin
        if (sys_rst) begin
            page_mask_ff  <= '0;
            page_base_ff  <= 6'h00;
            page_ptr_ff   <= 3'h0;
            page_armed_ff <= 1'b0;
            go_tgl_ff     <= 1'b0;
            program_enable_cmd_tgl_ff   <= 1'b0;
            program_disable_cmd_tgl_ff   <= 1'b0;
        end else begin
            // armed only between the last data bit and the next edge
            page_armed_ff <= 1'b0;
            if (hdr_done && !chip_select_n && !busy_l2_ff) begin
                if (hdr_kind == eeprom_pkg::CK_WRITE || hdr_kind == eeprom_pkg::CK_PAGE) begin
                    page_base_ff <= nxt_shift[8:3];
                    page_ptr_ff  <= nxt_shift[2:0];
                    page_mask_ff <= '0;
                end
                if (hdr_kind == eeprom_pkg::CK_PROGRAM_ENABLE_CMD)
                    program_enable_cmd_tgl_ff <= ~program_enable_cmd_tgl_ff;
                if (hdr_kind == eeprom_pkg::CK_PROGRAM_DISABLE_CMD)
                    program_disable_cmd_tgl_ff <= ~program_disable_cmd_tgl_ff;
            end
            if (word_done && !chip_select_n) begin
                page_buf_ff[page_ptr_ff]  <= nxt_shift;
                page_mask_ff[page_ptr_ff] <= 1'b1;
                page_ptr_ff               <= page_ptr_ff + 3'h1;
                if (is_page_ff)
                    page_armed_ff <= 1'b1;
                else
                    go_tgl_ff <= ~go_tgl_ff;
            end
        end
    end

    // read data out on falling edges
    always_ff @(negedge serial_clock_in or posedge link_clr) begin
        if (link_clr) begin
            drive_ff   <= 1'b0;
            out_ff     <= 1'b0;
            rd_ptr_ff  <= '0;
            rd_idx_ff  <= 4'h0;
            rd_word_ff <= 16'h0000;
        end else if (state_ff == eeprom_pkg::LS_READ) begin
            if (!drive_ff || rd_idx_ff == 4'h0) begin
                // first word at the header address, then wrap at the top
                rd_ptr_ff  <= drive_ff ? rd_ptr_ff + 9'h001 : cmd_addr_ff;
                out_ff     <= mem_ff[drive_ff ? rd_ptr_ff + 9'h001 : cmd_addr_ff][15];
                rd_word_ff <= {mem_ff[drive_ff ? rd_ptr_ff + 9'h001 : cmd_addr_ff][14:0], 1'b0};
                rd_idx_ff  <= `EE_LAST_BIT;
                drive_ff   <= 1'b1;
            end else begin
                out_ff     <= rd_word_ff[15];
                rd_word_ff <= {rd_word_ff[14:0], 1'b0};
                rd_idx_ff  <= rd_idx_ff - 4'h1;
            end
        end
    end

    // status rides on the core-side ready flop, so it needs no link clock
    assign status_mode   = !chip_select_n && status_req_ff && !status_done_ff;
    assign serial_out    = drive_ff ? out_ff : ready_ff;
    assign serial_out_en = drive_ff | status_mode;
    assign ready_out     = ready_ff;

    // pin and link levels into the core domain
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cs_sync_ff    <= 3'h7;
            abort_sync_ff <= 2'h0;
            armed_sync_ff <= 2'h0;
            go_sync_ff    <= 3'h0;
            program_enable_cmd_sync_ff  <= 3'h0;
            program_disable_cmd_sync_ff  <= 3'h0;
        end else begin
            cs_sync_ff    <= {cs_sync_ff[1:0], chip_select_n};
            abort_sync_ff <= {abort_sync_ff[0], prog_abort};
            armed_sync_ff <= {armed_sync_ff[0], page_armed_ff};
            go_sync_ff    <= {go_sync_ff[1:0], go_tgl_ff};
            program_enable_cmd_sync_ff  <= {program_enable_cmd_sync_ff[1:0], program_enable_cmd_tgl_ff};
            program_disable_cmd_sync_ff  <= {program_disable_cmd_sync_ff[1:0], program_disable_cmd_tgl_ff};
        end
    end

    // single write on its toggle, page write on the select rise
    assign commit_req = (go_sync_ff[2] ^ go_sync_ff[1])
                      | (cs_sync_ff[1] & ~cs_sync_ff[2] & armed_sync_ff[1]);
    assign prog_end   = !ready_ff && !abort_sync_ff[1] && (timer_ff == PROG_CYCLES - 1);

    // write-enable latch, cleared at power-up
    always_ff @(posedge core_clk) begin
        if (sys_rst)
            wel_ff <= `EE_WEL_RST;
        else if (program_enable_cmd_sync_ff[2] ^ program_enable_cmd_sync_ff[1])
            wel_ff <= 1'b1;
        else if (program_disable_cmd_sync_ff[2] ^ program_disable_cmd_sync_ff[1])
            wel_ff <= 1'b0;
    end

    // self-timed programming period
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ready_ff   <= `EE_READY_RST;
            timer_ff   <= 32'h0000_0000;
            cm_mask_ff <= '0;
            cm_base_ff <= 6'h00;
        end else if (ready_ff) begin
            // link buffer is still while the core copies it
            if (commit_req && wel_ff && !abort_sync_ff[1]) begin
                ready_ff   <= 1'b0;
                timer_ff   <= 32'h0000_0000;
                cm_buf_ff  <= page_buf_ff;
                cm_mask_ff <= page_mask_ff;
                cm_base_ff <= page_base_ff;
            end
        end else if (abort_sync_ff[1]) begin
            ready_ff <= 1'b1;
        end else if (prog_end) begin
            ready_ff <= 1'b1;
        end else begin
            timer_ff <= timer_ff + 32'h0000_0001;
        end
    end

    // an aborted cycle leaves the old word, one valid undefined outcome
    always_ff @(posedge core_clk) begin
        if (prog_end) begin
            for (int i = 0; i < `EE_PAGE_WORDS; i++) begin
                if (cm_mask_ff[i])
                    mem_ff[{cm_base_ff, 3'(i)}] <= cm_buf_ff[i];
            end
        end
    end

endmodule // serial_eeprom_cmd

// [dv/serial_eeprom_cmd_assertions.sv]
/*
 port checker of the command block
 assumes binding to serial_eeprom_cmd, below
*/
`include "eeprom_consts.svh"
module serial_eeprom_cmd_assertions #(
    parameter int unsigned PROG_CYCLES = 100000
) (
    // core side
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic prog_abort,
    input wire logic ready_out,
    // serial link
    input wire logic serial_clock_in,
    input wire logic chip_select_n,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_en
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] busy_cnt_ff;
    logic [7:0]  bit_cnt_ff;
    logic [15:0] hdr_ff;

    always_ff @(posedge core_clk) begin
        busy_cnt_ff <= (sys_rst || ready_out) ? 32'h0 : busy_cnt_ff + 32'h1;
    end
    // select high clears the count, as it clears the receiver
    always_ff @(posedge serial_clock_in or posedge chip_select_n) begin
        if (chip_select_n) begin
            bit_cnt_ff <= 8'h0;
        end else if (bit_cnt_ff != 8'hff) begin
            bit_cnt_ff <= bit_cnt_ff + 8'h1;
        end
    end
    always_ff @(posedge serial_clock_in) begin
        if (bit_cnt_ff < 8'h10) begin
            hdr_ff <= {hdr_ff[14:0], serial_in};
        end
    end

    sequence abort_held;
        prog_abort [*4];
    endsequence
    sequence read_hdr_done;
        bit_cnt_ff == 8'h10 && hdr_ff[15:9] == `EE_OP_READ && ready_out;
    endsequence

    AST_OE_DESELECT: assert property (@(posedge core_clk) disable iff (sys_rst)
        chip_select_n |-> !serial_out_en) else $error("output on while deselected");
    AST_BUSY_OUT: assert property (@(posedge core_clk) disable iff (sys_rst)
        serial_out_en && !ready_out |-> !serial_out) else $error("busy not shown");
    AST_ABORT: assert property (@(posedge core_clk) disable iff (sys_rst)
        abort_held |-> ready_out) else $error("busy while reset pin high");
    AST_BUSY_LEN: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(ready_out) |-> busy_cnt_ff inside {[PROG_CYCLES-1:PROG_CYCLES+1]} || $past(prog_abort, 2))
        else $error("busy spell of wrong length");
    AST_BUSY_MAX: assert property (@(posedge core_clk) disable iff (sys_rst)
        busy_cnt_ff <= PROG_CYCLES + 1) else $error("busy spell too long");
    AST_RST_READY: assert property (@(posedge core_clk) disable iff (sys_rst)
        $fell(sys_rst) |-> ready_out && !serial_out_en) else $error("not ready after reset");
    AST_HDR_QUIET: assert property (@(posedge serial_clock_in) disable iff (sys_rst || chip_select_n)
        bit_cnt_ff inside {[2:15]} |-> !serial_out_en) else $error("output on during header");
    AST_READ_START: assert property (@(posedge serial_clock_in) disable iff (sys_rst || chip_select_n)
        read_hdr_done |-> serial_out_en) else $error("read data not driven");
endmodule // serial_eeprom_cmd_assertions

bind serial_eeprom_cmd serial_eeprom_cmd_assertions #(.PROG_CYCLES(PROG_CYCLES)) i_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .prog_abort(prog_abort), .ready_out(ready_out),
    .serial_clock_in(serial_clock_in), .chip_select_n(chip_select_n), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_en(serial_out_en)
);

// [dv/host_port.sv]
/*
 model of the controller serial port
 assumes the device on the other end of the three wires
*/
module host_port (
    // serial link
    output logic      serial_clock_in,
    output logic      chip_select_n,
    output logic      serial_in,
    input  wire logic serial_out,
    input  wire logic serial_out_en
);
    timeunit 1ns;
    timeprecision 1ps;
    // clock idles high; status drops it before select falls, raises it after select rises
    initial begin
        serial_clock_in = 1'b1;
        chip_select_n = 1'b1;
        serial_in = 1'b0;
    end
    // nb bits out of w, then nrd bits read back, msb first
    task automatic shift(input logic [15:0] w[$], input int nb, input int nrd, output logic [31:0] got);
        int i;
        got = 32'h0;
        #7;
        chip_select_n = 1'b0; // fall with clock high
        #16;
        for (i = 0; i < nb + nrd; i++) begin
            serial_clock_in = 1'b0;
            serial_in = (i < nb) ? w[i / 16][15 - i % 16] : ~serial_in;
            #16;
            serial_clock_in = 1'b1;
            // a dropped enable reads as unknown, never as a lucky bit
            if (i >= nb) begin
                got = {got[30:0], serial_out_en ? serial_out : 1'bx};
            end
            #16;
        end
        #4;
        chip_select_n = 1'b1; // low all frame, up before next rise
        serial_in = ~serial_in;
        #300; // select high between instructions
    endtask
    task automatic status(output logic en, output logic lvl);
        #7;
        serial_clock_in = 1'b0;
        #10;
        chip_select_n = 1'b0;
        #40;
        en = serial_out_en;
        lvl = serial_out;
        chip_select_n = 1'b1;
        #10;
        serial_clock_in = 1'b1;
        #300;
    endtask
endmodule // host_port

// [dv/serial_eeprom_cmd_test.sv]
/*
 self-checking bench of the command block
 assumes host_port as far side and the bound checker
*/
`include "eeprom_consts.svh"
module serial_eeprom_cmd_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned PROG = 200;
    logic core_clk;
    logic sys_rst;
    logic prog_abort;
    logic serial_clock_in;
    logic chip_select_n;
    logic serial_in;
    logic serial_out;
    logic serial_out_en;
    logic ready_out;
    int   n_fail;
    int   checks_done;

    serial_eeprom_cmd #(.PROG_CYCLES(PROG)) i_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .serial_clock_in(serial_clock_in),
        .chip_select_n(chip_select_n), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_en(serial_out_en), .prog_abort(prog_abort), .ready_out(ready_out)
    );
    host_port i_host (
        .serial_clock_in(serial_clock_in), .chip_select_n(chip_select_n), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_en(serial_out_en)
    );

    always #25 core_clk = ~core_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [15:0] d, input int nb);
        logic [31:0] g;
        i_host.shift('{{`EE_OP_WRITE, a[8], a[7:0]}, d}, nb, 0, g);
    endtask
    task automatic rd(input logic [8:0] a, input int n, output logic [31:0] g);
        i_host.shift('{{`EE_OP_READ, a[8], a[7:0]}}, 16, n, g);
    endtask
    task automatic cmd(input logic [7:0] op);
        logic [31:0] g;
        i_host.shift('{{op, 8'h00}}, 16, 0, g);
    endtask
    // bounded waits: a lost busy spell must not hang the run
    task automatic wait_busy(input logic exp);
        int  i;
        logic seen;
        seen = 1'b0;
        for (i = 0; i < 20 && !seen; i++) begin
            @(negedge core_clk);
            seen = (ready_out === 1'b0);
        end
        check(32'(seen), 32'(exp));
        for (i = 0; i < PROG + 40 && ready_out !== 1'b1; i++) begin
            @(negedge core_clk);
        end
        check(32'(ready_out), 32'h1);
    endtask

    task automatic t_protect();
        logic [31:0] g;
        wr(9'h000, 16'ha1b2, 32);
        wait_busy(1'b0);
        cmd(`EE_OP_PROGRAM_ENABLE_CMD);
        wr(9'h000, 16'ha1b2, 32);
        wait_busy(1'b1);
        cmd(`EE_OP_PROGRAM_DISABLE_CMD);
        wr(9'h000, 16'h1111, 32);
        wait_busy(1'b0);
        rd(9'h000, 16, g);
        check(g, 32'h0000a1b2);
    endtask
    task automatic t_busy();
        logic        en;
        logic        lvl;
        logic [31:0] g;
        cmd(`EE_OP_PROGRAM_ENABLE_CMD);
        wr(9'h006, 16'h0f0f, 32);
        i_host.status(en, lvl);
        check(32'({en, lvl}), 32'h2);
        wr(9'h006, 16'h7777, 32);
        wait_busy(1'b1);
        i_host.status(en, lvl);
        check(32'({en, lvl}), 32'h3);
        rd(9'h006, 16, g);
        check(g, 32'h00000f0f);
    endtask
    task automatic t_page();
        logic [15:0] q[$];
        logic [31:0] g;
        int          i;
        q = '{{`EE_OP_PAGE, 1'b1, 8'hf8}};
        for (i = 0; i < 10; i++) begin
            q.push_back(16'h1000 + 16'(i));
        end
        i_host.shift(q, 176, 0, g);
        wait_busy(1'b1);
        rd(9'h1f8, 32, g);
        check(g, 32'h10081009);
        rd(9'h1ff, 32, g);
        check(g, 32'h1007a1b2);
    endtask
    task automatic t_abort();
        logic [31:0] g;
        wr(9'h020, 16'h5555, 32);
        check(32'(ready_out), 32'h0);
        @(negedge core_clk);
        prog_abort = 1'b1;
        repeat (6) @(negedge core_clk);
        check(32'(ready_out), 32'h1);
        wr(9'h021, 16'h5555, 32);
        wait_busy(1'b0);
        cmd(`EE_OP_PROGRAM_DISABLE_CMD);
        cmd(`EE_OP_PROGRAM_ENABLE_CMD);
        rd(9'h000, 16, g);
        check(g, 32'h0000a1b2);
        @(negedge core_clk);
        prog_abort = 1'b0;
    endtask
    task automatic t_nop_cut();
        logic [31:0] g;
        cmd(8'hff);
        wr(9'h000, 16'h2222, 24);
        wait_busy(1'b0);
        rd(9'h000, 16, g);
        check(g, 32'h0000a1b2);
        wr(9'h001, 16'h3c3c, 32);
        wait_busy(1'b1);
        rd(9'h001, 16, g);
        check(g, 32'h00003c3c);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // run needs well under 300 us; this span only cuts hangs
    initial begin
        #2000000;
        n_fail++;
        wrap_up();
    end
    initial begin
        core_clk = 1'b0;
        sys_rst = 1'b1;
        prog_abort = 1'b0; // held low except inside t_abort
        n_fail = 0;
        checks_done = 0;
        repeat (4) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (6) @(negedge core_clk);
        t_protect();
        t_busy();
        t_page();
        t_abort();
        t_nop_cut();
        wrap_up();
    end
endmodule // serial_eeprom_cmd_test
